/* File: dim_mapper.sv */
// Purpose: Map four optocoupled input terminals onto drive functions over APB
// Assumes: APB master on mclk; analog words and limits from same-clock logic
// Notes: Function vector bit n is the function with code n
// Notes on behaviour
// - Each terminal has a function code 00 to 1E in its low byte, and 00 means no function.
// - Codes 01 to 0B give servo enable through pulse-command inhibit in the listed order.
// - Codes 0C, 0E, 0F are speed segment bits 1-3, 10 clears residue, 11-12 torque stage bits.
// - Codes 13 to 16 are gantry sync, gantry zero, origin switch and homing start.
// - Codes 17, 18 invert speed and torque analog, 19 is external alarm, 1A emergency stop.
// - Codes 1B, 1C are probe 1 and 2, 1D requests pole detection, 1E negates position command.
// - Logic select 0 low, 1 high, 2 falling, 3 rising, 4 both edges.
// - A low-speed input level is accepted only after it persists longer than 3.2 ms.
// - Speed source bit 0 picks analog one, 1 picks analog two for the speed command.
// - Torque source bit 0 picks analog two, 1 picks analog one for the torque command.
// - Two 16-bit power-on words, reset zero, name functions forced active.
// - Terminals two to four use the same codes and selects, each set on its own.
// - An active torque-limit switch applies the external limit, otherwise the internal one.
// - In internal torque mode the two torque stage bits index one of four presets.
`timescale 1ns/1ps
`include "dim_params.svh"
module dim_mapper
  import dim_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = `DIM_FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Input terminal pins
  input  wire logic             input_terminal_one,
  input  wire logic             input_terminal_two,
  input  wire logic             input_terminal_three,
  input  wire logic             input_terminal_four,
  // Analog command words
  input  wire dim_pkg::dim_cmd_t analog_in_one,
  input  wire dim_pkg::dim_cmd_t analog_in_two,
  output dim_pkg::dim_cmd_t     speed_cmd,
  output dim_pkg::dim_cmd_t     torque_cmd,
  // Torque limits
  input  wire dim_pkg::dim_cmd_t internal_forward_torque_limit,
  input  wire dim_pkg::dim_cmd_t internal_reverse_torque_limit,
  input  wire dim_pkg::dim_cmd_t external_forward_torque_limit,
  input  wire dim_pkg::dim_cmd_t external_reverse_torque_limit,
  output dim_pkg::dim_cmd_t     forward_torque_limit,
  output dim_pkg::dim_cmd_t     reverse_torque_limit,
  // Internal torque presets
  input  wire logic             internal_torque_mode,
  output logic [1:0]            torque_preset_index,
  // Function vector and named functions
  output dim_pkg::dim_func_t    func_active,
  output logic                  servo_enable,
  output logic                  alarm_clear,
  output logic                  forward_overtravel,
  output logic                  reverse_overtravel,
  output logic                  control_mode_switch,
  output logic                  proportional_control,
  output logic                  forward_torque_limit_switch,
  output logic                  reverse_torque_limit_switch,
  output logic                  gain_switch,
  output logic                  zero_lock,
  output logic                  pulse_command_inhibit,
  output logic [2:0]            speed_segment_select,
  output logic                  position_residue_clear,
  output logic [1:0]            torque_stage_select,
  output logic                  gantry_sync_enable,
  output logic                  gantry_align_zero,
  output logic                  origin_switch,
  output logic                  homing_start,
  output logic                  speed_analog_invert,
  output logic                  torque_analog_invert,
  output logic                  external_alarm,
  output logic                  emergency_stop,
  output logic                  probe_one,
  output logic                  probe_two,
  output logic                  pole_detect_request,
  output logic                  position_cmd_negate
);
  localparam int NTERM = 4;

  // Function code to one-hot vector; unlisted codes give nothing
  function automatic dim_func_t func_decode(input logic [7:0] code);
    dim_func_t v;
    v = '0;
    if (code != `DIM_FUNC_NONE && code != `DIM_FUNC_GAP && code <= `DIM_FUNC_LAST) begin
      v[code[4:0]] = 1'b1;
    end
    return v;
  endfunction

  // Saturating negate keeps the most negative word in range
  function automatic dim_cmd_t sat_negate(input dim_cmd_t x);
    dim_cmd_t r;
    r = (x == 16'sh8000) ? 16'sh7fff : -x;
    return r;
  endfunction

  logic [15:0] po_first_q;
  logic [15:0] po_second_q;
  logic [15:0] analog_sel_q;
  logic [15:0] term_cfg_q [NTERM];
  logic [NTERM-1:0] pins;
  logic [NTERM-1:0] level;
  logic [NTERM-1:0] hit;
  dim_func_t        term_func [NTERM];
  dim_func_t        func_d;
  dim_func_t        func_q;
  dim_func_t        po_func;
  logic [31:0]      prdata_q;
  logic             setup;
  logic             wr_access;
  logic             mapped;
  dim_cmd_t         speed_q;
  dim_cmd_t         torque_q;
  dim_cmd_t         fwd_lim_q;
  dim_cmd_t         rev_lim_q;
  logic [1:0]       preset_q;

  assign pins = {input_terminal_four, input_terminal_three,
                 input_terminal_two, input_terminal_one};

  // Per-terminal filter, activation and decode
  genvar g;
  generate
    for (g = 0; g < NTERM; g++) begin : g_term
      dim_in_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
      ) u_filter (
        .mclk   (mclk),
        .resetn (resetn),
        .pin    (pins[g]),
        .level  (level[g])
      );
      dim_activate u_act (
        .mclk      (mclk),
        .resetn    (resetn),
        .level     (level[g]),
        .logic_sel (term_cfg_q[g][`DIM_CFG_LOGIC_MSB:`DIM_CFG_LOGIC_LSB]),
        .hit       (hit[g])
      );
      // Same codes and selects on every terminal, each from its own register
      assign term_func[g] = hit[g] ?
          func_decode(term_cfg_q[g][`DIM_CFG_FUNC_MSB:`DIM_CFG_FUNC_LSB]) : '0;
    end
  endgenerate

  // Power-on words: first holds codes 1 to 16, second codes 17 to 30
  always_comb begin
    po_func = '0;
    for (int i = 0; i < 16; i++) begin
      po_func[i + 1] = po_first_q[i];
    end
    for (int i = 0; i < 14; i++) begin
      po_func[i + `DIM_PO_SECOND_BASE] = po_second_q[i];
    end
  end

  always_comb begin
    func_d = po_func;
    for (int t = 0; t < NTERM; t++) begin
      func_d = func_d | term_func[t];
    end
    func_d[0] = 1'b0;
    func_d[13] = 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      func_q <= '0;
    end else begin
      func_q <= func_d;
    end
  end

  // APB decode
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `DIM_OFF_PO_FIRST, `DIM_OFF_PO_SECOND, `DIM_OFF_ANALOG_SEL,
      `DIM_OFF_TERM_ONE, `DIM_OFF_TERM_TWO, `DIM_OFF_TERM_THREE,
      `DIM_OFF_TERM_FOUR, `DIM_OFF_INPUT_STATUS, `DIM_OFF_FUNC_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      po_first_q   <= `DIM_RST_PO;
      po_second_q  <= `DIM_RST_PO;
      analog_sel_q <= `DIM_RST_ANALOG_SEL;
    end else if (wr_access) begin
      if (paddr == `DIM_OFF_PO_FIRST) begin
        po_first_q <= pwdata[15:0];
      end
      if (paddr == `DIM_OFF_PO_SECOND) begin
        po_second_q <= pwdata[15:0];
      end
      if (paddr == `DIM_OFF_ANALOG_SEL) begin
        analog_sel_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int t = 0; t < NTERM; t++) begin
        term_cfg_q[t] <= `DIM_RST_TERM;
      end
    end else if (wr_access) begin
      if (paddr == `DIM_OFF_TERM_ONE) begin
        term_cfg_q[0] <= pwdata[15:0];
      end
      if (paddr == `DIM_OFF_TERM_TWO) begin
        term_cfg_q[1] <= pwdata[15:0];
      end
      if (paddr == `DIM_OFF_TERM_THREE) begin
        term_cfg_q[2] <= pwdata[15:0];
      end
      if (paddr == `DIM_OFF_TERM_FOUR) begin
        term_cfg_q[3] <= pwdata[15:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      unique case (paddr)
        `DIM_OFF_PO_FIRST:     prdata_q <= {16'h0000, po_first_q};
        `DIM_OFF_PO_SECOND:    prdata_q <= {16'h0000, po_second_q};
        `DIM_OFF_ANALOG_SEL:   prdata_q <= {16'h0000, analog_sel_q};
        `DIM_OFF_TERM_ONE:     prdata_q <= {16'h0000, term_cfg_q[0]};
        `DIM_OFF_TERM_TWO:     prdata_q <= {16'h0000, term_cfg_q[1]};
        `DIM_OFF_TERM_THREE:   prdata_q <= {16'h0000, term_cfg_q[2]};
        `DIM_OFF_TERM_FOUR:    prdata_q <= {16'h0000, term_cfg_q[3]};
        `DIM_OFF_INPUT_STATUS: prdata_q <= {28'h0000000, level};
        `DIM_OFF_FUNC_STATUS:  prdata_q <= {1'b0, func_q};
        default:               prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Analog routing with optional inversion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      speed_q <= 16'sh0000;
    end else begin
      if (analog_sel_q[`DIM_SEL_SPEED_BIT]) begin
        speed_q <= func_q[23] ? sat_negate(analog_in_two) : analog_in_two;
      end else begin
        speed_q <= func_q[23] ? sat_negate(analog_in_one) : analog_in_one;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      torque_q <= 16'sh0000;
    end else begin
      if (analog_sel_q[`DIM_SEL_TORQUE_BIT]) begin
        torque_q <= func_q[24] ? sat_negate(analog_in_one) : analog_in_one;
      end else begin
        torque_q <= func_q[24] ? sat_negate(analog_in_two) : analog_in_two;
      end
    end
  end

  assign speed_cmd  = speed_q;
  assign torque_cmd = torque_q;

  // Torque limit selection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fwd_lim_q <= 16'sh0000;
      rev_lim_q <= 16'sh0000;
    end else begin
      fwd_lim_q <= func_q[7] ? external_forward_torque_limit
                             : internal_forward_torque_limit;
      rev_lim_q <= func_q[8] ? external_reverse_torque_limit
                             : internal_reverse_torque_limit;
    end
  end

  assign forward_torque_limit = fwd_lim_q;
  assign reverse_torque_limit = rev_lim_q;

  // Preset index, stage 1 is the low bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      preset_q <= 2'h0;
    end else if (internal_torque_mode) begin
      preset_q <= {func_q[18], func_q[17]};
    end else begin
      preset_q <= 2'h0;
    end
  end

  assign torque_preset_index = preset_q;

  // Named function outputs
  assign func_active                 = func_q;
  assign servo_enable                = func_q[1];
  assign alarm_clear                 = func_q[2];
  assign forward_overtravel          = func_q[3];
  assign reverse_overtravel          = func_q[4];
  assign control_mode_switch         = func_q[5];
  assign proportional_control        = func_q[6];
  assign forward_torque_limit_switch = func_q[7];
  assign reverse_torque_limit_switch = func_q[8];
  assign gain_switch                 = func_q[9];
  assign zero_lock                   = func_q[10];
  assign pulse_command_inhibit       = func_q[11];
  assign speed_segment_select        = {func_q[15], func_q[14], func_q[12]};
  assign position_residue_clear      = func_q[16];
  assign torque_stage_select         = {func_q[18], func_q[17]};
  assign gantry_sync_enable          = func_q[19];
  assign gantry_align_zero           = func_q[20];
  assign origin_switch               = func_q[21];
  assign homing_start                = func_q[22];
  assign speed_analog_invert         = func_q[23];
  assign torque_analog_invert        = func_q[24];
  assign external_alarm              = func_q[25];
  assign emergency_stop              = func_q[26];
  assign probe_one                   = func_q[27];
  assign probe_two                   = func_q[28];
  assign pole_detect_request         = func_q[29];
  assign position_cmd_negate         = func_q[30];
endmodule

/* File: dim_params.svh */
// Purpose: Offsets, field positions, reset values and timing of the input mapper
// Assumes: 32-bit APB, one register per aligned word
// Notes: Included by the mapper and its input filter
`ifndef DIM_PARAMS_SVH
`define DIM_PARAMS_SVH

`define DIM_OFF_PO_FIRST      8'h00
`define DIM_OFF_PO_SECOND     8'h04
`define DIM_OFF_ANALOG_SEL    8'h08
`define DIM_OFF_TERM_ONE      8'h0c
`define DIM_OFF_TERM_TWO      8'h10
`define DIM_OFF_TERM_THREE    8'h14
`define DIM_OFF_TERM_FOUR     8'h18
`define DIM_OFF_INPUT_STATUS  8'h1c
`define DIM_OFF_FUNC_STATUS   8'h20

`define DIM_RST_PO            16'h0000
`define DIM_RST_ANALOG_SEL    16'h0000
`define DIM_RST_TERM          16'h0000

`define DIM_CFG_FUNC_LSB      0
`define DIM_CFG_FUNC_MSB      7
`define DIM_CFG_LOGIC_LSB     8
`define DIM_CFG_LOGIC_MSB     11
`define DIM_SEL_SPEED_BIT     0
`define DIM_SEL_TORQUE_BIT    1

`define DIM_FUNC_NONE         8'h00
`define DIM_FUNC_GAP          8'h0d
`define DIM_FUNC_LAST         8'h1e
`define DIM_PO_SECOND_BASE    17

`define DIM_FILTER_TIME_NS    3200000
`define DIM_CLK_PERIOD_NS     100
`define DIM_FILTER_CYCLES     ((`DIM_FILTER_TIME_NS + `DIM_CLK_PERIOD_NS - 1) / `DIM_CLK_PERIOD_NS)

`endif

/* File: dim_pkg.sv */
// Purpose: Types shared by the input mapper
// Assumes: Logic-select codes 0 to 4 in enum order
// Notes: None
package dim_pkg;
  typedef enum logic [3:0] {
    DIM_ACT_LOW,
    DIM_ACT_HIGH,
    DIM_ACT_FALL,
    DIM_ACT_RISE,
    DIM_ACT_BOTH
  } dim_act_e;
  typedef logic [30:0]        dim_func_t;
  typedef logic signed [15:0] dim_cmd_t;
endpackage

/* File: dim_in_filter.sv */
// Purpose: Synchronise one input pin and accept a new level only after it persists
// Assumes: Pin is asynchronous to mclk
// Notes: Level changes after more than FILTER_CYCLES stable cycles
`timescale 1ns/1ps
`include "dim_params.svh"
module dim_in_filter #(
  parameter int unsigned FILTER_CYCLES = `DIM_FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic        meta_q;
  logic        sync_q;
  logic [15:0] cnt_q;
  logic        level_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // Count only while the synchronised pin differs from the accepted level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= 16'h0000;
      level_q <= 1'b0;
    end else if (sync_q == level_q) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= FILTER_CYCLES[15:0]) begin
      level_q <= sync_q;
      cnt_q   <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign level = level_q;
endmodule

/* File: dim_activate.sv */
// Purpose: Turn a filtered terminal level into a function hit per logic select
// Assumes: Level comes from the same clock domain
// Notes: Edge modes give one-cycle hits; unknown select codes never hit
`timescale 1ns/1ps
module dim_activate
  import dim_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Level and selection
  input  wire logic       level,
  input  wire logic [3:0] logic_sel,
  output logic            hit
);
  logic prev_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  always_comb begin
    hit = 1'b0;
    unique case (logic_sel)
      DIM_ACT_LOW:  hit = ~level;
      DIM_ACT_HIGH: hit = level;
      DIM_ACT_FALL: hit = prev_q & ~level;
      DIM_ACT_RISE: hit = ~prev_q & level;
      DIM_ACT_BOTH: hit = prev_q ^ level;
      default:      hit = 1'b0;
    endcase
  end
endmodule

/* File: dim_mapper_checker.sv */
// Purpose: Concurrent checks on the mapper ports
// Assumes: One mclk domain, zero-wait APB slave
// Notes: Named outputs mirror the function vector
`timescale 1ns/1ps
module dim_mapper_checker
  import dim_pkg::*;
(
  // Clock, reset and APB
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // Functions
  input wire dim_pkg::dim_func_t func_active,
  input wire logic              servo_enable,
  input wire logic [2:0]        speed_segment_select,
  input wire logic [1:0]        torque_stage_select,
  input wire logic              origin_switch,
  input wire logic              emergency_stop,
  input wire logic              probe_one,
  // Limits and presets
  input wire dim_pkg::dim_cmd_t internal_forward_torque_limit,
  input wire dim_pkg::dim_cmd_t internal_reverse_torque_limit,
  input wire dim_pkg::dim_cmd_t external_forward_torque_limit,
  input wire dim_pkg::dim_cmd_t external_reverse_torque_limit,
  input wire dim_pkg::dim_cmd_t forward_torque_limit,
  input wire dim_pkg::dim_cmd_t reverse_torque_limit,
  input wire logic              internal_torque_mode,
  input wire logic [1:0]        torque_preset_index
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  a_slverr_map: assert property (psel && penable && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > 8'h20)) else $error("pslverr wrong for address");
  a_gap_dead: assert property (func_active[0] == 1'b0 && func_active[13] == 1'b0)
    else $error("unassigned code active");
  a_servo_bit: assert property (servo_enable == func_active[1])
    else $error("servo enable not code 1");
  a_segment_bits: assert property (speed_segment_select ==
    {func_active[15], func_active[14], func_active[12]}) else $error("segment bits wrong");
  a_stage_bits: assert property (torque_stage_select == func_active[18:17])
    else $error("stage bits wrong");
  a_origin_bit: assert property (origin_switch == func_active[21])
    else $error("origin switch not code 21");
  a_stop_probe: assert property (emergency_stop == func_active[26]
    && probe_one == func_active[27]) else $error("stop or probe bit wrong");
  a_fwd_limit: assert property ($past(resetn) |-> forward_torque_limit ==
    ($past(func_active[7]) ? $past(external_forward_torque_limit)
    : $past(internal_forward_torque_limit))) else $error("forward limit source wrong");
  a_rev_limit: assert property ($past(resetn) |-> reverse_torque_limit ==
    ($past(func_active[8]) ? $past(external_reverse_torque_limit)
    : $past(internal_reverse_torque_limit))) else $error("reverse limit source wrong");
  a_preset_idx: assert property ($past(resetn) |-> torque_preset_index ==
    ($past(internal_torque_mode) ? $past(func_active[18:17]) : 2'b00))
    else $error("preset index wrong");
endmodule

/* File: dim_ctrl_model.sv */
// Purpose: External controller driving the four optocoupled terminals
// Assumes: Levels commanded by the bench
// Notes: Optocoupler off reads low; pins always driven
`timescale 1ns/1ps
module dim_ctrl_model (
  // Clock
  input  wire logic       mclk,
  // Commanded levels and pins
  input  wire logic [3:0] want,
  output logic [3:0]      pins = 4'h0
);
  // Output stage of the controller lags one edge
  always @(posedge mclk) pins <= want;
endmodule

/* File: test_digital_input_function_mapper.sv */
// Purpose: Self-checking bench for the input mapper
// Assumes: Short filter count, 100 ns clock
// Notes: Terminal pins come from the controller model
`timescale 1ns/1ps
module test_digital_input_function_mapper;
  import dim_pkg::*;
  localparam int unsigned FC = 4;
  logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  want = 4'h0, pins;
  dim_cmd_t    ain1 = 16'h1234, ain2 = 16'hfa99, spd, trq, fl, rl;
  dim_cmd_t    ifl = 16'h0064, irl = 16'hff9c, efl = 16'h00c8, erl = 16'hff38;
  logic        itm = 0;
  logic [1:0]  tpi;
  dim_func_t   fa;
  wire [30:0]  nv;
  assign nv[0]  = 1'b0;
  assign nv[13] = 1'b0;
  int          errors = 0, n_compared = 0, n;
  dim_mapper #(.FILTER_CYCLES(FC)) uut (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .input_terminal_one(pins[0]), .input_terminal_two(pins[1]),
    .input_terminal_three(pins[2]), .input_terminal_four(pins[3]),
    .analog_in_one(ain1), .analog_in_two(ain2), .speed_cmd(spd), .torque_cmd(trq),
    .internal_forward_torque_limit(ifl), .internal_reverse_torque_limit(irl),
    .external_forward_torque_limit(efl), .external_reverse_torque_limit(erl),
    .forward_torque_limit(fl), .reverse_torque_limit(rl), .internal_torque_mode(itm),
    .torque_preset_index(tpi), .func_active(fa), .servo_enable(nv[1]), .alarm_clear(nv[2]),
    .forward_overtravel(nv[3]), .reverse_overtravel(nv[4]), .control_mode_switch(nv[5]),
    .proportional_control(nv[6]), .forward_torque_limit_switch(nv[7]),
    .reverse_torque_limit_switch(nv[8]), .gain_switch(nv[9]), .zero_lock(nv[10]),
    .pulse_command_inhibit(nv[11]), .speed_segment_select({nv[15], nv[14], nv[12]}),
    .position_residue_clear(nv[16]), .torque_stage_select(nv[18:17]),
    .gantry_sync_enable(nv[19]), .gantry_align_zero(nv[20]), .origin_switch(nv[21]),
    .homing_start(nv[22]), .speed_analog_invert(nv[23]), .torque_analog_invert(nv[24]),
    .external_alarm(nv[25]), .emergency_stop(nv[26]), .probe_one(nv[27]),
    .probe_two(nv[28]), .pole_detect_request(nv[29]), .position_cmd_negate(nv[30])
  );
  dim_ctrl_model ctrl (.mclk, .want, .pins);
  always #50 mclk = ~mclk;
  task automatic test_done();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      errors++;
      test_done();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic cnt(input int k, input int b);
    n = 0;
    repeat (k) begin
      @(posedge mclk);
      if (fa[b] === 1'b1) n++;
    end
  endtask
  task automatic t_regs();
    for (int a = 0; a <= 8'h18; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b1, 8'h0c, 32'hffff_0a1b);
    apb(1'b0, 8'h0c, 32'h0);
    chk("config readback", 32'h0000_0a1b, rd);
    chk("bad select no hit", 32'h0, 32'(fa));
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, 8'h20, 32'hffff_ffff);
    apb(1'b0, 8'h20, 32'h0);
    chk("status read only", 32'h0, rd);
  endtask
  task automatic t_poweron();
    apb(1'b1, 8'h00, 32'hffff);
    cyc(2);
    chk("power-on first", 32'h0001_dffe, 32'(fa));
    apb(1'b1, 8'h04, 32'h3fff);
    apb(1'b0, 8'h20, 32'h0);
    chk("power-on both", 32'h7fff_dffe, rd);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk("reset clears word", 32'h0, rd);
    chk("reset clears functions", 32'h0, 32'(fa));
  endtask
  task automatic t_codes();
    logic [31:0] exp;
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, 8'(8'h0c + 4 * (c % 4)), 32'h0100 | 32'(c));
      want <= 4'(1 << (c % 4));
      cyc(FC + 8);
      exp = (c == 0 || c == 8'h0d || c > 8'h1e) ? 32'h0 : 32'h1 << c;
      chk("function by code", exp, 32'(fa));
      chk("named outputs", exp, {1'b0, nv});
      want <= 4'h0;
      cyc(FC + 8);
      chk("function released", 32'h0, 32'(fa));
      apb(1'b1, 8'(8'h0c + 4 * (c % 4)), 32'h0);
    end
  endtask
  task automatic t_filter();
    apb(1'b1, 8'h10, 32'h0101);
    want <= 4'h2;
    cyc(FC);
    want <= 4'h0;
    cyc(FC + 8);
    chk("short pulse lost", 32'h0, 32'(fa));
    want <= 4'h2;
    cyc(FC + 2);
    chk("before filter", 32'h0, 32'(fa));
    cyc(6);
    chk("after filter", 32'h2, 32'(fa));
    apb(1'b0, 8'h1c, 32'h0);
    chk("input status", 32'h2, rd);
    want <= 4'h0;
    apb(1'b1, 8'h10, 32'h0);
  endtask
  task automatic t_low();
    apb(1'b1, 8'h14, 32'h0019);
    cyc(3);
    chk("active low idle", 32'h1, {31'h0, fa[25]});
    want <= 4'h4;
    cyc(FC + 8);
    chk("active low released", 32'h0, {31'h0, fa[25]});
    apb(1'b1, 8'h14, 32'h0);
    want <= 4'h0;
    cyc(FC + 8);
  endtask
  task automatic t_edges();
    for (int m = 2; m <= 4; m++) begin
      apb(1'b1, 8'h18, 32'(m) << 8 | 32'h1b);
      want <= 4'h8;
      cnt(FC + 10, 27);
      chk("pulses on rise", 32'(m != 2), 32'(n));
      want <= 4'h0;
      cnt(FC + 10, 27);
      chk("pulses on fall", 32'(m != 3), 32'(n));
    end
    apb(1'b1, 8'h18, 32'h0);
  endtask
  task automatic t_analog();
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h08, 32'(s));
      cyc(3);
      chk("speed source", {16'h0, s[0] ? ain2 : ain1}, {16'h0, spd});
      chk("torque source", {16'h0, s[1] ? ain1 : ain2}, {16'h0, trq});
    end
    apb(1'b1, 8'h04, 32'h00c0);
    cyc(3);
    chk("speed negated", 32'h0567, {16'h0, spd});
    chk("torque negated", 32'hedcc, {16'h0, trq});
    ain1 <= 16'h8000;
    apb(1'b1, 8'h08, 32'h0);
    cyc(3);
    chk("negate saturates", 32'h7fff, {16'h0, spd});
    apb(1'b1, 8'h04, 32'h0);
    ain1 <= 16'h1234;
  endtask
  task automatic t_limits();
    cyc(2);
    chk("fwd internal", {16'h0, ifl}, {16'h0, fl});
    apb(1'b1, 8'h00, 32'h00c0);
    cyc(3);
    chk("fwd external", {16'h0, efl}, {16'h0, fl});
    chk("rev external", {16'h0, erl}, {16'h0, rl});
    itm <= 1'b1;
    apb(1'b1, 8'h04, 32'h0002);
    cyc(3);
    chk("preset index", 32'h2, {30'h0, tpi});
    itm <= 1'b0;
    cyc(3);
    chk("preset off", 32'h0, {30'h0, tpi});
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_poweron();
    t_codes();
    t_filter();
    t_low();
    t_edges();
    t_analog();
    t_limits();
    test_done();
  end
endmodule
bind dim_mapper dim_mapper_checker chk_i (
  .mclk, .resetn, .psel, .penable, .paddr, .pready, .pslverr, .func_active, .servo_enable,
  .speed_segment_select, .torque_stage_select, .origin_switch, .emergency_stop, .probe_one,
  .internal_forward_torque_limit, .internal_reverse_torque_limit,
  .external_forward_torque_limit, .external_reverse_torque_limit, .forward_torque_limit,
  .reverse_torque_limit, .internal_torque_mode, .torque_preset_index
);
